/* File: lrv_pkg.sv */
package lrv_pkg;
  // register byte addresses behind the serial host interface
  localparam logic [7:0] ADDR_C_CEILING = 8'h18;
  localparam logic [7:0] ADDR_D_PRIMARY = 8'h19;
  localparam logic [7:0] ADDR_D_ALTERNATE = 8'h1a;
  localparam logic [7:0] ADDR_D_CEILING = 8'h1b;

  // field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_POWER_SAVE = 6;
  localparam int BIT_SOURCE_SELECT = 6;
  localparam int CODE_MSB = 5;

  // ceiling values that leave the ceiling register writable
  localparam logic [5:0] CEIL_OPEN_LOW = 6'h00;
  localparam logic [5:0] CEIL_OPEN_HIGH = 6'h3f;

  // one-time-programmed defaults (first variant)
  localparam logic [7:0] RST_C_CEILING = 8'h3c;
  localparam logic [7:0] RST_D_PRIMARY = 8'h24;
  localparam logic [7:0] RST_D_ALTERNATE = 8'h22;
  localparam logic [7:0] RST_D_CEILING = 8'h28;
endpackage

/* File: lrv_ceiling.sv */
`timescale 1ns/1ns
module lrv_ceiling #(
  parameter logic [7:0] RST_VALUE = 8'h3f,
  parameter logic       FIXED_TOP = 1'b0
) (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  // host write
  input  wire logic       i_wr,
  input  wire logic [5:0] i_wdata,
  // ceiling state
  output logic [5:0]      o_ceiling,
  output logic            o_locked
);
  logic [5:0] ceiling_reg;
  logic       locked;

  assign locked = (ceiling_reg != lrv_pkg::CEIL_OPEN_LOW) &&
                  (ceiling_reg != lrv_pkg::CEIL_OPEN_HIGH); // see (RQ2)
  assign o_ceiling = ceiling_reg;
  assign o_locked = locked;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      ceiling_reg <= RST_VALUE[5:0] | {FIXED_TOP, 5'h00}; // see (RQ8)
    end
    else if (i_wr && !locked) // see (RQ2)
    begin
      ceiling_reg <= i_wdata | {FIXED_TOP, 5'h00};
    end
  end

  a_ceil_lock_holds: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ2)
    (i_wr && locked) |=> $stable(ceiling_reg))
    else $error("locked ceiling changed on write");
endmodule

/* File: lrv_regs.sv */
`timescale 1ns/1ns
// How it works
// (RQ1) regulator C ceiling field is the top code regulator C may take.
// (RQ2) ceiling not 0x00 or 0x3F makes the ceiling register ignore writes.
// (RQ3) primary bit 6 picks primary or alternate code as active code.
// (RQ4) top code bit of both D voltage registers is always one.
// (RQ5) alternate bit 7 switches regulator D on, clear switches it off.
// (RQ6) alternate bit 6 set selects power save, clear normal mode.
// (RQ7) low six bits of each voltage register hold the voltage code.
// (RQ8) reset reloads every register with its programmed default.
// (RQ9) regulator D ceiling caps codes written to both D voltage registers.
// (RQ10) reserved bits read zero and ignore writes.
module lrv_regs (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  // register port from the host interface decoder
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic [7:0]      o_reg_rdata,
  // regulator C core
  output logic [5:0]      o_c_ceiling,
  // regulator D core and sequencer
  output logic [5:0]      o_d_code,
  output logic            o_d_enable,
  output logic            o_d_power_save
);
  logic [4:0] prim_code_reg;
  logic       src_alt_reg;
  logic [4:0] alt_code_reg;
  logic       enable_reg;
  logic       save_reg;
  logic [5:0] c_ceiling;
  logic [5:0] d_ceiling;
  logic       c_locked;
  logic       d_locked;
  logic [5:0] prim_code;
  logic [5:0] alt_code;
  logic [5:0] wr_code;
  logic       wr_prim;
  logic       wr_alt;
  logic       code_ok;
  logic [7:0] rd_next;

  assign prim_code = {1'b1, prim_code_reg}; // see (RQ4)
  assign alt_code = {1'b1, alt_code_reg}; // see (RQ4)
  assign wr_code = {1'b1, i_reg_wdata[4:0]}; // see (RQ4) (RQ7)
  assign code_ok = (wr_code <= d_ceiling); // see (RQ9)
  assign wr_prim = i_reg_wr && (i_reg_addr == lrv_pkg::ADDR_D_PRIMARY);
  assign wr_alt = i_reg_wr && (i_reg_addr == lrv_pkg::ADDR_D_ALTERNATE);

  lrv_ceiling #(
    .RST_VALUE (lrv_pkg::RST_C_CEILING),
    .FIXED_TOP (1'b0)
  ) u_c_ceiling (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_wr      (i_reg_wr && (i_reg_addr == lrv_pkg::ADDR_C_CEILING)),
    .i_wdata   (i_reg_wdata[5:0]),
    .o_ceiling (c_ceiling),
    .o_locked  (c_locked)
  );

  lrv_ceiling #(
    .RST_VALUE (lrv_pkg::RST_D_CEILING),
    .FIXED_TOP (1'b1)
  ) u_d_ceiling (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_wr      (i_reg_wr && (i_reg_addr == lrv_pkg::ADDR_D_CEILING)),
    .i_wdata   (i_reg_wdata[5:0]),
    .o_ceiling (d_ceiling),
    .o_locked  (d_locked)
  );

  // primary register: select bit always taken, code only when at or under cap
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      src_alt_reg <= lrv_pkg::RST_D_PRIMARY[lrv_pkg::BIT_SOURCE_SELECT]; // see (RQ8)
      prim_code_reg <= lrv_pkg::RST_D_PRIMARY[4:0]; // see (RQ8)
    end
    else if (wr_prim)
    begin
      src_alt_reg <= i_reg_wdata[lrv_pkg::BIT_SOURCE_SELECT];
      if (code_ok) // see (RQ9)
      begin
        prim_code_reg <= i_reg_wdata[4:0];
      end
    end
  end

  // alternate register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      enable_reg <= lrv_pkg::RST_D_ALTERNATE[lrv_pkg::BIT_ENABLE]; // see (RQ5) (RQ8)
      save_reg <= lrv_pkg::RST_D_ALTERNATE[lrv_pkg::BIT_POWER_SAVE]; // see (RQ8)
      alt_code_reg <= lrv_pkg::RST_D_ALTERNATE[4:0]; // see (RQ8)
    end
    else if (wr_alt)
    begin
      enable_reg <= i_reg_wdata[lrv_pkg::BIT_ENABLE]; // see (RQ5)
      save_reg <= i_reg_wdata[lrv_pkg::BIT_POWER_SAVE]; // see (RQ6)
      if (code_ok) // see (RQ9)
      begin
        alt_code_reg <= i_reg_wdata[4:0];
      end
    end
  end

  // core outputs registered so the regulator sees glitch-free levels
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_d_code <= 6'h00;
      o_d_enable <= 1'b0;
      o_d_power_save <= 1'b0;
      o_c_ceiling <= 6'h00;
    end
    else
    begin
      o_d_code <= src_alt_reg ? alt_code : prim_code; // see (RQ3)
      o_d_enable <= enable_reg; // see (RQ5)
      o_d_power_save <= save_reg; // see (RQ6)
      o_c_ceiling <= c_ceiling; // see (RQ1)
    end
  end

  // read mux; reserved and unmapped bits answer zero
  always_comb
  begin
    rd_next = 8'h00;
    case (i_reg_addr)
      lrv_pkg::ADDR_C_CEILING:   rd_next = {2'b00, c_ceiling}; // see (RQ10)
      lrv_pkg::ADDR_D_PRIMARY:   rd_next = {1'b0, src_alt_reg, prim_code}; // see (RQ10)
      lrv_pkg::ADDR_D_ALTERNATE: rd_next = {enable_reg, save_reg, alt_code};
      lrv_pkg::ADDR_D_CEILING:   rd_next = {2'b00, d_ceiling}; // see (RQ10)
      default:                   rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_reg_rdata <= 8'h00;
    end
    else if (i_reg_rd)
    begin
      o_reg_rdata <= rd_next;
    end
  end

  a_top_bit_forced: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ4)
    $past(!i_reset) |-> o_d_code[lrv_pkg::CODE_MSB])
    else $error("active code top bit not one");

  a_code_over_cap: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ9)
    (wr_prim && !code_ok) |=> $stable(prim_code_reg))
    else $error("primary code above cap accepted");

  // an over-cap write still takes the mode bits
  a_alt_over_cap: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ9)
    (wr_alt && !code_ok) |=>
      $stable(alt_code_reg) && save_reg == $past(i_reg_wdata[lrv_pkg::BIT_POWER_SAVE]))
    else $error("alternate code above cap accepted");

  a_source_select: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ3)
    $past(!i_reset) |->
      o_d_code == ($past(src_alt_reg) ? $past(alt_code) : $past(prim_code)))
    else $error("active code from wrong source");

  a_enable_write: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ5)
    wr_alt |-> ##2 o_d_enable == $past(i_reg_wdata[lrv_pkg::BIT_ENABLE], 2))
    else $error("enable bit not applied");

  a_save_write: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ6)
    wr_alt |=> save_reg == $past(i_reg_wdata[lrv_pkg::BIT_POWER_SAVE]))
    else $error("power save bit not applied");

  a_code_write: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ7)
    (wr_prim && code_ok) |=> prim_code == $past(wr_code))
    else $error("accepted code not stored");

  a_alt_code_write: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ7)
    (wr_alt && code_ok) |=> alt_code == $past(wr_code))
    else $error("accepted alternate code not stored");

  // implication from the reset edge avoids relying on history before the first edge
  a_reset_default: assert property (@(posedge i_clk_sys) // see (RQ8)
    i_reset |=> {src_alt_reg, prim_code_reg} ==
      {lrv_pkg::RST_D_PRIMARY[lrv_pkg::BIT_SOURCE_SELECT], lrv_pkg::RST_D_PRIMARY[4:0]})
    else $error("primary default not reloaded");

  a_alt_default: assert property (@(posedge i_clk_sys) // see (RQ8)
    i_reset |=> {enable_reg, save_reg, alt_code_reg} ==
      {lrv_pkg::RST_D_ALTERNATE[lrv_pkg::BIT_ENABLE],
       lrv_pkg::RST_D_ALTERNATE[lrv_pkg::BIT_POWER_SAVE],
       lrv_pkg::RST_D_ALTERNATE[4:0]})
    else $error("alternate default not reloaded");

  a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ10)
    (i_reg_rd && i_reg_addr == lrv_pkg::ADDR_D_PRIMARY) |=> !o_reg_rdata[7])
    else $error("reserved bit read nonzero");

  a_ceiling_reserved: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ10)
    (i_reg_rd && (i_reg_addr == lrv_pkg::ADDR_C_CEILING ||
                  i_reg_addr == lrv_pkg::ADDR_D_CEILING)) |=> o_reg_rdata[7:6] == 2'b00)
    else $error("ceiling reserved bits read nonzero");

  a_c_lock: assert property (@(posedge i_clk_sys) disable iff (i_reset) // see (RQ2) (RQ1)
    (c_locked && i_reg_wr && i_reg_addr == lrv_pkg::ADDR_C_CEILING) ##1 1 |->
      ##1 o_c_ceiling == $past(c_ceiling, 2))
    else $error("locked regulator C ceiling changed");

  c_cap_reject: cover property (@(posedge i_clk_sys) wr_prim && !code_ok);
  c_source_alt: cover property (@(posedge i_clk_sys)
    wr_prim && i_reg_wdata[lrv_pkg::BIT_SOURCE_SELECT] ##2 o_d_code == alt_code);
  c_lock_write: cover property (@(posedge i_clk_sys)
    d_locked && i_reg_wr && i_reg_addr == lrv_pkg::ADDR_D_CEILING);
  c_enable_on: cover property (@(posedge i_clk_sys) $rose(o_d_enable));
  c_save_on: cover property (@(posedge i_clk_sys) $rose(o_d_power_save));
endmodule

/* File: lrv_regs_bench.sv */
`timescale 1ns/1ns
module lrv_regs_bench;
  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [5:0] c_ceiling;
  logic [5:0] d_code;
  logic       d_enable;
  logic       d_power_save;
  int         fail_count = 0;
  int         checks_done = 0;

  lrv_regs u_lrv_regs (
    .i_clk_sys      (clk_sys),
    .i_reset        (reset),
    .i_reg_addr     (reg_addr),
    .i_reg_wr       (reg_wr),
    .i_reg_rd       (reg_rd),
    .i_reg_wdata    (reg_wdata),
    .o_reg_rdata    (reg_rdata),
    .o_c_ceiling    (c_ceiling),
    .o_d_code       (d_code),
    .o_d_enable     (d_enable),
    .o_d_power_save (d_power_save)
  );

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_out(input string what, input logic [5:0] exp, input logic [5:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  // rdata is registered on the taking edge, so look just after it
  task automatic read_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    cmp_byte($sformatf("reg %h", addr), exp, reg_rdata);
  endtask

  // core outputs lag a write by two edges
  task automatic outs_chk(input logic [5:0] ceil, input logic [5:0] code, input logic en,
                          input logic ps);
    repeat (2) @(posedge clk_sys);
    #1;
    cmp_out("c ceiling", ceil, c_ceiling);
    cmp_out("d code", code, d_code);
    cmp_out("d enable", {5'h00, en}, {5'h00, d_enable});
    cmp_out("d power save", {5'h00, ps}, {5'h00, d_power_save});
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
  endtask

  task automatic test_defaults();
    read_chk(lrv_pkg::ADDR_C_CEILING, lrv_pkg::RST_C_CEILING);
    read_chk(lrv_pkg::ADDR_D_PRIMARY, lrv_pkg::RST_D_PRIMARY);
    read_chk(lrv_pkg::ADDR_D_ALTERNATE, lrv_pkg::RST_D_ALTERNATE);
    read_chk(lrv_pkg::ADDR_D_CEILING, lrv_pkg::RST_D_CEILING);
    outs_chk(6'h3c, 6'h24, 1'b0, 1'b0);
    $display("test defaults done");
  endtask

  task automatic test_ceiling_lock();
    write_reg(lrv_pkg::ADDR_C_CEILING, 8'h01);
    read_chk(lrv_pkg::ADDR_C_CEILING, 8'h3c);
    write_reg(lrv_pkg::ADDR_D_CEILING, 8'h3f);
    read_chk(lrv_pkg::ADDR_D_CEILING, 8'h28);
    write_reg(8'h30, 8'hff);
    read_chk(8'h30, 8'h00);
    outs_chk(6'h3c, 6'h24, 1'b0, 1'b0);
    $display("test ceiling lock done");
  endtask

  task automatic test_select_modes();
    write_reg(lrv_pkg::ADDR_D_ALTERNATE, 8'he5);
    read_chk(lrv_pkg::ADDR_D_ALTERNATE, 8'he5);
    outs_chk(6'h3c, 6'h24, 1'b1, 1'b1);
    // reserved bit 7 dropped, code top bit forced high
    write_reg(lrv_pkg::ADDR_D_PRIMARY, 8'h83);
    write_reg(lrv_pkg::ADDR_D_PRIMARY, 8'hc3);
    read_chk(lrv_pkg::ADDR_D_PRIMARY, 8'h63);
    outs_chk(6'h3c, 6'h25, 1'b1, 1'b1);
    $display("test select modes done");
  endtask

  task automatic test_over_cap();
    write_reg(lrv_pkg::ADDR_D_ALTERNATE, 8'h1f);
    read_chk(lrv_pkg::ADDR_D_ALTERNATE, 8'h25);
    outs_chk(6'h3c, 6'h25, 1'b0, 1'b0);
    write_reg(lrv_pkg::ADDR_D_PRIMARY, 8'h1f);
    read_chk(lrv_pkg::ADDR_D_PRIMARY, 8'h23);
    outs_chk(6'h3c, 6'h23, 1'b0, 1'b0);
    write_reg(lrv_pkg::ADDR_D_PRIMARY, 8'h08);
    read_chk(lrv_pkg::ADDR_D_PRIMARY, 8'h28);
    $display("test over cap done");
  endtask

  initial
  begin
    #20000;
    fail_count++;
    give_verdict();
  end

  initial
  begin
    do_reset();
    test_defaults();
    test_ceiling_lock();
    test_select_modes();
    test_over_cap();
    do_reset();
    test_defaults();
    give_verdict();
  end
endmodule
